/* logic/serial_tx_top.sv */
// asynchronous serial transmitter: registers, holding buffer, pin driver
// assumes a single 100 MHz clock, synchronous reset and a same-clock master
`timescale 1ns/1ns
module serial_tx_top
  import tx_pkg::*;
#(
  parameter int OVS = BAUD_OVERSAMPLE
) (
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_CE,
  input wire logic I_SLEEP,
  input wire bus_req_t I_BUS,
  output logic [7:0] O_RDATA,
  output logic O_IRQ,
  output logic O_BAUD_TICK,
  output pin_out_t O_PIN
);
  // ************************************************************
  // state
  // ************************************************************
  logic [7:0] tx_ctrl_r;
  logic [7:0] rcv_ctrl_r;
  logic [7:0] hold_r;
  logic hold_full_r;
  logic [7:0] baud_div_r;
  logic [7:0] irq_en_r;
  logic [EVT_W-1:0] evt_stat_r;
  logic [EVT_W-1:0] evt_en_r;
  logic active_q_r;
  logic [7:0] rdata_nxt;
  logic [EVT_W-1:0] evt_stat_nxt;

  // ************************************************************
  // address decode
  // ************************************************************
  wire wr_go = I_BUS.wr && I_CE;
  wire rd_go = I_BUS.rd && I_CE;
  wire wr_tx_ctrl = wr_go && (I_BUS.addr == ADDR_TX_CTRL);
  wire wr_rcv_ctrl = wr_go && (I_BUS.addr == ADDR_RCV_CTRL);
  wire wr_hold = wr_go && (I_BUS.addr == ADDR_TX_HOLD);
  wire wr_div = wr_go && (I_BUS.addr == ADDR_BAUD_DIV);
  wire wr_irq_en = wr_go && (I_BUS.addr == ADDR_IRQ_ENABLES);
  wire wr_evt_clr = wr_go && (I_BUS.addr == ADDR_EVT_CLEAR);
  wire wr_evt_en = wr_go && (I_BUS.addr == ADDR_EVT_ENABLE);
  wire rd_tx_ctrl = rd_go && (I_BUS.addr == ADDR_TX_CTRL);

  // ************************************************************
  // control terms
  // ************************************************************
  wire port_en = rcv_ctrl_r[RCC_PORT_EN];
  // clocked mode is not built here, so the transmitter stays idle in it
  wire tx_active = port_en && tx_ctrl_r[TXC_ENABLE] && !tx_ctrl_r[TXC_SYNC_SEL];
  wire baud_run = port_en && !I_SLEEP;
  wire shift_ce = I_CE && !I_SLEEP;
  wire baud_tick;
  wire sh_line;
  wire sh_busy;
  wire sh_last;
  wire sh_done;
  // the shifter counts as empty in the tick that ends its stop bit
  wire sh_free = !sh_busy || sh_last;
  wire transfer = shift_ce && tx_active && hold_full_r && baud_tick && sh_free;
  wire buf_empty_flag = !hold_full_r;
  wire shifter_empty_status = !sh_busy;
  wire nine_sel = tx_ctrl_r[TXC_NINE_SEL];
  wire [8:0] sh_data = {tx_ctrl_r[TXC_NINTH_VAL], hold_r};
  wire abort_evt = active_q_r && !tx_active && sh_busy;
  wire [EVT_W-1:0] evt_set = {abort_evt, sh_done};
  wire [7:0] tx_ctrl_view = {tx_ctrl_r[7:2], shifter_empty_status, tx_ctrl_r[0]};
  wire [7:0] irq_flag_view = {6'h00, buf_empty_flag, 1'b0};
  wire irq_nxt = (|(evt_stat_r & evt_en_r)) || (buf_empty_flag && irq_en_r[IRQ_BUF_EMPTY]);

  // ************************************************************
  // baud generator and shifter
  // ************************************************************
  baud_gen #(
    .W(BAUD_DIV_W)
  ) u_baud (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(I_CE),
    .i_run(baud_run),
    .i_div(baud_div_r),
    .o_tick(baud_tick)
  );

  frame_shifter #(
    .OVS(OVS)
  ) u_shift (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_ce(shift_ce),
    .i_clear(!tx_active),
    .i_tick(baud_tick),
    .i_load(transfer),
    .i_nine(nine_sel),
    .i_data(sh_data),
    .o_line(sh_line),
    .o_busy(sh_busy),
    .o_last(sh_last),
    .o_done(sh_done)
  );

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rdata_nxt = 8'h00;
    case (I_BUS.addr)
      ADDR_RCV_CTRL: rdata_nxt = rcv_ctrl_r;
      ADDR_TX_CTRL: rdata_nxt = tx_ctrl_view;
      ADDR_TX_HOLD: rdata_nxt = hold_r;
      ADDR_BAUD_DIV: rdata_nxt = baud_div_r;
      ADDR_IRQ_FLAGS: rdata_nxt = irq_flag_view;
      ADDR_IRQ_ENABLES: rdata_nxt = irq_en_r;
      ADDR_EVT_STATUS: rdata_nxt = {6'h00, evt_stat_r};
      ADDR_EVT_ENABLE: rdata_nxt = {6'h00, evt_en_r};
      default: rdata_nxt = 8'h00;
    endcase
  end

  // hardware set wins over a software clear in the same cycle
  always_comb begin
    evt_stat_nxt = evt_stat_r;
    if (wr_evt_clr) begin
      evt_stat_nxt = evt_stat_nxt & ~I_BUS.wdata[EVT_W-1:0];
    end
    evt_stat_nxt = evt_stat_nxt | evt_set;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      tx_ctrl_r <= TXC_RST;
      rcv_ctrl_r <= RCC_RST;
      baud_div_r <= BAUD_DIV_RST;
      irq_en_r <= IRQE_RST;
      evt_en_r <= '0;
    end else begin
      if (wr_tx_ctrl) begin
        tx_ctrl_r <= I_BUS.wdata & TXC_WR_MASK;
      end
      if (wr_rcv_ctrl) begin
        rcv_ctrl_r <= I_BUS.wdata & RCC_WR_MASK;
      end
      if (wr_div) begin
        baud_div_r <= I_BUS.wdata;
      end
      if (wr_irq_en) begin
        irq_en_r <= I_BUS.wdata & IRQE_WR_MASK;
      end
      if (wr_evt_en) begin
        evt_en_r <= I_BUS.wdata[EVT_W-1:0];
      end
    end
  end

  // a write in the transfer cycle refills the buffer, so it stays full
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      hold_r <= HOLD_RST;
      hold_full_r <= 1'b0;
    end else if (wr_hold) begin
      hold_r <= I_BUS.wdata;
      hold_full_r <= 1'b1;
    end else if (transfer) begin
      hold_full_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      evt_stat_r <= '0;
      active_q_r <= 1'b0;
    end else if (I_CE) begin
      evt_stat_r <= evt_stat_nxt;
      active_q_r <= tx_active;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_RDATA <= 8'h00;
      O_IRQ <= 1'b0;
      O_BAUD_TICK <= 1'b0;
      O_PIN <= '{out: 1'b1, oe: 1'b0};
    end else if (I_CE) begin
      O_RDATA <= rd_go ? rdata_nxt : 8'h00;
      O_IRQ <= irq_nxt;
      O_BAUD_TICK <= baud_tick;
      O_PIN.out <= tx_active ? sh_line : 1'b1;
      O_PIN.oe <= tx_active;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_hold_write_clears: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    wr_hold |=> !buf_empty_flag
  ) else $error("buffer write did not clear the empty flag");

  chk_xfer_sets_flag: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer && !wr_hold |=> buf_empty_flag && sh_busy
  ) else $error("transfer did not empty the buffer or start the shifter");

  chk_xfer_cause: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer |-> hold_full_r && baud_tick && (!sh_busy || u_shift.bits_r == 4'h1)
  ) else $error("transfer without data, tick or finished stop bit");

  chk_sleep_no_tick: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_SLEEP && I_CE ##1 I_SLEEP |-> !baud_tick && !transfer
  ) else $error("baud tick or transfer during sleep");

  chk_disable_floats: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && !tx_active |=> !O_PIN.oe && O_PIN.out
  ) else $error("pin still driven after transmit disable");

  chk_disable_resets: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    shift_ce && !tx_active |=> !sh_busy
  ) else $error("shifter not reset after disable");

  chk_idle_high: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && !sh_busy && !transfer |=> O_PIN.out
  ) else $error("line not high while idle");

  chk_start_low: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer ##1 I_CE && tx_active |=> !O_PIN.out
  ) else $error("start bit not low after transfer");

  chk_status_read: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    rd_tx_ctrl |=> O_RDATA[TXC_SHIFT_EMPTY] == $past(shifter_empty_status)
  ) else $error("shifter-empty status read back wrong");

  chk_baud_period: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    baud_tick && I_CE && baud_run && baud_div_r == 8'h01 ##1 I_CE && baud_run
      |-> !baud_tick ##1 baud_tick
  ) else $error("baud period is not divisor plus one");

  chk_nine_frame: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer && nine_sel |=> u_shift.bits_r == 4'hb
      && u_shift.sr_r[9] == $past(tx_ctrl_r[TXC_NINTH_VAL])
  ) else $error("ninth bit not taken from control register");

  chk_eight_frame: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer && !nine_sel |=> u_shift.bits_r == 4'ha && u_shift.sr_r[9]
  ) else $error("eight-bit frame length or stop bit wrong");

  chk_flag_sticky: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    buf_empty_flag && !wr_hold |=> buf_empty_flag
  ) else $error("buffer-empty flag cleared without a buffer write");

  chk_flag_no_enable: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer && !wr_hold && !irq_en_r[IRQ_BUF_EMPTY] |=> buf_empty_flag
  ) else $error("buffer-empty flag did not set with its enable off");

  chk_full_until_xfer: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    !buf_empty_flag && !transfer |=> !buf_empty_flag
  ) else $error("buffer emptied without a transfer");

  chk_irq_raised: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && buf_empty_flag && irq_en_r[IRQ_BUF_EMPTY] |=> O_IRQ
  ) else $error("enabled buffer-empty flag did not raise the interrupt");

  chk_irq_masked: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && irq_en_r == 8'h00 && evt_en_r == '0 |=> !O_IRQ
  ) else $error("interrupt raised with every enable off");

  chk_tick_pulse: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    baud_tick && I_CE && u_baud.cnt_r != 8'h00 |=> !baud_tick
  ) else $error("baud tick longer than one cycle");

  chk_bit_steady: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    shift_ce && tx_active && sh_busy && !u_shift.bit_end |=> $stable(sh_line)
  ) else $error("line changed between bit boundaries");

  chk_load_cause: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    $rose(sh_busy) |-> $past(baud_tick) && $past(tx_active) && $past(hold_full_r)
  ) else $error("shifter started without tick, enable or buffered data");

  chk_enabled_idle: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_CE && tx_active && !sh_busy && !transfer |=> O_PIN.oe && O_PIN.out
  ) else $error("enabled idle line not driven high");

  chk_abort_event: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    $fell(tx_active) && sh_busy && I_CE |=> evt_stat_r[EVT_ABORT]
  ) else $error("mid-frame disable did not flag an abort");

  chk_stop_high: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    sh_busy && u_shift.bits_r == 4'h1 |-> sh_line
  ) else $error("last bit of a frame is not a high stop bit");

  chk_lsb_first: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    transfer |=> u_shift.sr_r[1] == $past(hold_r[0])
  ) else $error("first data bit is not the least significant bit");

  chk_sleep_frozen: assert property (
    @(posedge I_CLK) disable iff (I_RST)
    I_SLEEP |=> $stable(sh_line)
  ) else $error("shifter moved during sleep");
endmodule // serial_tx_top

/* inc/tx_pkg.sv */
// shared constants and carriers for the asynchronous serial transmitter
// assumes a byte-wide register port with a bank bit at address bit 5
package tx_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [5:0] ADDR_RCV_CTRL = 6'h13;
  localparam logic [5:0] ADDR_TX_CTRL = 6'h15;
  localparam logic [5:0] ADDR_TX_HOLD = 6'h16;
  localparam logic [5:0] ADDR_BAUD_DIV = 6'h17;
  localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h36;
  localparam logic [5:0] ADDR_IRQ_ENABLES = 6'h37;
  localparam logic [5:0] ADDR_EVT_STATUS = 6'h38;
  localparam logic [5:0] ADDR_EVT_CLEAR = 6'h39;
  localparam logic [5:0] ADDR_EVT_ENABLE = 6'h3a;
  // ************************************************************
  // field positions and masks
  // ************************************************************
  localparam int TXC_NINE_SEL = 6;
  localparam int TXC_ENABLE = 5;
  localparam int TXC_SYNC_SEL = 4;
  localparam int TXC_SHIFT_EMPTY = 1;
  localparam int TXC_NINTH_VAL = 0;
  localparam int RCC_PORT_EN = 7;
  localparam int IRQ_BUF_EMPTY = 1;
  localparam logic [7:0] TXC_WR_MASK = 8'hf1;
  localparam logic [7:0] RCC_WR_MASK = 8'hf0;
  localparam logic [7:0] IRQE_WR_MASK = 8'h02;
  localparam int EVT_FRAME_SENT = 0;
  localparam int EVT_ABORT = 1;
  localparam int EVT_W = 2;
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [7:0] TXC_RST = 8'h02;
  localparam logic [7:0] RCC_RST = 8'h00;
  localparam logic [7:0] IRQF_RST = 8'h02;
  localparam logic [7:0] IRQE_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'h00;
  localparam int BAUD_OVERSAMPLE = 64;
  localparam int BAUD_DIV_W = 8;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic out;
    logic oe;
  } pin_out_t;
endpackage

/* logic/baud_gen.sv */
// reloading down-counter that paces the serial shift clock
// assumes the divisor is a stable register on the same clock
`timescale 1ns/1ns
module baud_gen #(
  parameter int W = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic [W-1:0] i_div,
  output logic o_tick
);
  logic [W-1:0] cnt_r;

  // period is divisor plus one; held at the divisor while stopped
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else if (i_ce) begin
      if (!i_run) begin
        cnt_r <= i_div;
        o_tick <= 1'b0;
      end else if (cnt_r == '0) begin
        cnt_r <= i_div;
        o_tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r - 1'b1;
        o_tick <= 1'b0;
      end
    end
  end
endmodule // baud_gen

/* logic/frame_shifter.sv */
// shift register that sends one start bit, 8 or 9 data bits, one stop bit
// assumes i_tick runs at the oversampled rate and i_load is a single pulse
`timescale 1ns/1ns
module frame_shifter #(
  parameter int OVS = 64
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic i_load,
  input wire logic i_nine,
  input wire logic [8:0] i_data,
  output logic o_line,
  output logic o_busy,
  output logic o_last,
  output logic o_done
);
  logic [10:0] sr_r;
  logic [$clog2(OVS)-1:0] sub_r;
  logic [3:0] bits_r;
  logic bit_end;

  assign bit_end = o_busy && i_tick && (sub_r == ($clog2(OVS))'(OVS - 1));
  assign o_last = bit_end && (bits_r == 4'h1);
  assign o_line = o_busy ? sr_r[0] : 1'b1;

  always_ff @(posedge i_clk) begin
    if (i_rst || (i_ce && i_clear)) begin
      sr_r <= '1;
      sub_r <= '0;
      bits_r <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= o_last;
      if (i_load) begin
        // start bit in bit 0, lsb first, stop bit last
        sr_r <= {1'b1, i_nine ? i_data[8] : 1'b1, i_data[7:0], 1'b0};
        bits_r <= i_nine ? 4'hb : 4'ha;
        sub_r <= '0;
        o_busy <= 1'b1;
      end else if (bit_end) begin
        sr_r <= {1'b1, sr_r[10:1]};
        sub_r <= '0;
        bits_r <= bits_r - 4'h1;
        o_busy <= !o_last;
      end else if (o_busy && i_tick) begin
        sub_r <= sub_r + 1'b1;
      end
    end
  end
endmodule // frame_shifter

/* verif/serial_rx_model.sv */
// far-end receiver model: decodes frames seen on the serial line
// assumes the line is pulled high when undriven and a bit lasts BIT_CYC clocks
`timescale 1ns/1ns
module serial_rx_model #(
  parameter int BIT_CYC = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_line,
  input wire logic i_nine,
  output logic [8:0] o_data,
  output logic o_stop,
  output int o_cnt
);
  logic [8:0] shf;
  int nb;
  // sampling on the falling edge keeps clear of the pin register updates
  initial begin
    o_data = '0;
    o_stop = 1'b0;
    o_cnt = 0;
    forever begin
      @(negedge i_clk);
      if (!i_rst && i_line === 1'b0) begin
        shf = '0;
        nb = i_nine ? 9 : 8;
        repeat (BIT_CYC / 2) @(negedge i_clk);
        for (int i = 0; i < nb; i++) begin
          repeat (BIT_CYC) @(negedge i_clk);
          shf[i] = i_line;
        end
        repeat (BIT_CYC) @(negedge i_clk);
        o_stop = i_line;
        o_data = shf;
        o_cnt = o_cnt + 1;
      end
    end
  end
endmodule // serial_rx_model

/* verif/async_serial_transmitter_tb_top.sv */
// self-checking bench for the serial transmitter with a far-end receiver model
// assumes a single clock, a shortened oversample count and a pulled-up line
`timescale 1ns/1ns
module async_serial_transmitter_tb_top;
  import tx_pkg::*;
  localparam int OVS_TB = 4;
  localparam int DIV = 1;
  localparam int BIT = OVS_TB * (DIV + 1);
  logic I_CLK;
  logic I_RST;
  logic I_SLEEP;
  logic nine_rx;
  bus_req_t I_BUS;
  logic [7:0] O_RDATA;
  logic O_IRQ;
  logic O_BAUD_TICK;
  pin_out_t O_PIN;
  logic [8:0] rx_data;
  logic rx_stop;
  int rx_cnt;
  int error_cnt;
  int cmp_count;
  int cyc;
  int base;
  int n;
  logic [7:0] rv;
  // undriven line floats high through the pull-up
  wire logic line_w = O_PIN.oe ? O_PIN.out : 1'b1;

  serial_tx_top #(.OVS(OVS_TB)) dut_u (.I_CLK(I_CLK), .I_RST(I_RST), .I_CE(1'b1),
    .I_SLEEP(I_SLEEP), .I_BUS(I_BUS), .O_RDATA(O_RDATA), .O_IRQ(O_IRQ),
    .O_BAUD_TICK(O_BAUD_TICK), .O_PIN(O_PIN));
  serial_rx_model #(.BIT_CYC(BIT)) rx_u (.i_clk(I_CLK), .i_rst(I_RST), .i_line(line_w),
    .i_nine(nine_rx), .o_data(rx_data), .o_stop(rx_stop), .o_cnt(rx_cnt));

  initial begin
    I_CLK = 1'b0;
    forever #5 I_CLK = ~I_CLK;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge I_CLK);
    I_BUS <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge I_CLK);
    I_BUS <= '0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge I_CLK);
    I_BUS <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge I_CLK);
    I_BUS <= '0;
    #1 rv = O_RDATA;
    check(rv, exp);
  endtask
  task automatic wait_frames(input int want);
    for (int k = 0; k < 3000 && rx_cnt < want; k++) @(posedge I_CLK);
  endtask
  task automatic tick_gap(output int g);
    g = 0;
    for (int k = 0; k < 600 && O_BAUD_TICK !== 1'b1; k++) begin
      @(posedge I_CLK);
      #1;
    end
    do begin
      @(posedge I_CLK);
      #1;
      g++;
    end while (O_BAUD_TICK !== 1'b1 && g < 600);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    I_RST = 1'b1;
    I_SLEEP = 1'b0;
    I_BUS = '0;
    nine_rx = 1'b0;
    repeat (20) @(posedge I_CLK);
    I_RST <= 1'b0;
    rchk(ADDR_TX_CTRL, TXC_RST);
    rchk(ADDR_IRQ_FLAGS, IRQF_RST);
    rchk(ADDR_IRQ_ENABLES, IRQE_RST);
    rchk(6'h20, 8'h00);
    check(O_PIN.oe, 1'b0);
    wr(ADDR_BAUD_DIV, 8'(DIV));
    wr(ADDR_RCV_CTRL, 8'h80);
    tick_gap(n);
    check(16'(n), 16'(DIV + 1));
    @(posedge I_CLK);
    I_SLEEP <= 1'b1;
    repeat (3) @(posedge I_CLK);
    n = 0;
    repeat (40) begin
      @(posedge I_CLK);
      #1;
      if (O_BAUD_TICK === 1'b1) n++;
    end
    check(16'(n), 16'h0000);
    @(posedge I_CLK);
    I_SLEEP <= 1'b0;
    // load before enabling; the flag follows the buffer, not the enable
    wr(ADDR_TX_HOLD, 8'ha5);
    rchk(ADDR_TX_HOLD, 8'ha5);
    rchk(ADDR_IRQ_FLAGS, 8'h00);
    wr(ADDR_IRQ_ENABLES, 8'h02);
    check(O_IRQ, 1'b0);
    base = rx_cnt;
    wr(ADDR_TX_CTRL, 8'h20);
    repeat (4) @(posedge I_CLK);
    rchk(ADDR_IRQ_FLAGS, 8'h02);
    check(O_IRQ, 1'b1);
    rchk(ADDR_TX_CTRL, 8'h20);
    wr(ADDR_IRQ_FLAGS, 8'h00);
    rchk(ADDR_IRQ_FLAGS, 8'h02);
    wait_frames(base + 1);
    check(rx_data, 9'h0a5);
    check(rx_stop, 1'b1);
    repeat (BIT) @(posedge I_CLK);
    rchk(ADDR_TX_CTRL, 8'h22);
    wr(ADDR_IRQ_ENABLES, 8'h00);
    // second byte waits in the buffer while the first shifts
    base = rx_cnt;
    wr(ADDR_TX_HOLD, 8'h3c);
    repeat (4) @(posedge I_CLK);
    wr(ADDR_TX_HOLD, 8'hc3);
    rchk(ADDR_IRQ_FLAGS, 8'h00);
    wait_frames(base + 1);
    check(rx_data, 9'h03c);
    wait_frames(base + 2);
    check(rx_data, 9'h0c3);
    nine_rx <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      base = rx_cnt;
      wr(ADDR_TX_CTRL, 8'h60 | 8'(b));
      wr(ADDR_TX_HOLD, 8'h96);
      wait_frames(base + 1);
      check(rx_data, {1'(b), 8'h96});
    end
    nine_rx <= 1'b0;
    wr(ADDR_TX_CTRL, 8'h20);
    // frame-sent event: raise, mask, clear
    repeat (BIT) @(posedge I_CLK);
    wr(ADDR_EVT_CLEAR, 8'h03);
    wr(ADDR_EVT_ENABLE, 8'h01);
    check(O_IRQ, 1'b0);
    base = rx_cnt;
    wr(ADDR_TX_HOLD, 8'h0f);
    wait_frames(base + 1);
    check(rx_data, 9'h00f);
    repeat (BIT) @(posedge I_CLK);
    check(O_IRQ, 1'b1);
    rchk(ADDR_EVT_STATUS, 8'h01);
    wr(ADDR_EVT_ENABLE, 8'h00);
    repeat (2) @(posedge I_CLK);
    check(O_IRQ, 1'b0);
    wr(ADDR_EVT_ENABLE, 8'h01);
    wr(ADDR_EVT_CLEAR, 8'h01);
    repeat (2) @(posedge I_CLK);
    check(O_IRQ, 1'b0);
    rchk(ADDR_EVT_STATUS, 8'h00);
    // clocked mode holds the transmitter off; buffer survives
    wr(ADDR_TX_CTRL, 8'h30);
    base = rx_cnt;
    wr(ADDR_TX_HOLD, 8'h11);
    repeat (200) @(posedge I_CLK);
    check(16'(rx_cnt - base), 16'h0000);
    check(O_PIN.oe, 1'b0);
    wr(ADDR_TX_CTRL, 8'h20);
    wait_frames(base + 1);
    check(rx_data, 9'h011);
    // mid-frame abort by either enable, then a clean restart
    for (int m = 0; m < 2; m++) begin
      // frame-sent lands a few cycles after the receiver sees the stop bit
      repeat (BIT) @(posedge I_CLK);
      wr(ADDR_EVT_CLEAR, 8'h03);
      wr(ADDR_TX_HOLD, 8'h55);
      repeat (3 * BIT) @(posedge I_CLK);
      wr(m == 0 ? ADDR_TX_CTRL : ADDR_RCV_CTRL, 8'h00);
      repeat (3) @(posedge I_CLK);
      check(O_PIN.oe, 1'b0);
      rchk(ADDR_EVT_STATUS, 8'h02);
      repeat (12 * BIT) @(posedge I_CLK);
      wr(ADDR_RCV_CTRL, 8'h80);
      wr(ADDR_TX_CTRL, 8'h20);
      base = rx_cnt;
      wr(ADDR_TX_HOLD, 8'h5a);
      wait_frames(base + 1);
      check(rx_data, 9'h05a);
    end
    tally_and_finish();
  end
endmodule // async_serial_transmitter_tb_top
